// ===== rtl/inertial_output_data_registers.v
// Output data register bank of an inertial sensing module, read over
// a four-wire serial port with 16-bit full-duplex frames.
// Assumes the sampling process delivers words on mclk; the serial pins
// are asynchronous and are sampled by mclk, which runs far faster
// than the serial clock (clock idles high, data in on rising edges).
// Limitation: the store is not reset, so a channel read before its
// first sample answers with unknown data bits; the first answer after
// reset is all zero, as nothing has been requested yet.
`timescale 1ns/100ps
`include "inertial_defs.vh"

module inertial_output_data_registers
(
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        cs_b,
  input  wire        sclk,
  input  wire        din,
  output wire        dout,
  output wire        dout_oe,
  input  wire        sample_valid,
  input  wire [3:0]  sample_channel,
  input  wire [13:0] sample_data,
  input  wire        error_alarm,
  output wire [10:0] fresh_sample_flag
);

  //////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // True when a six-bit byte address hits one of the output words
  function addr_hits;
    input [5:0] addr;
    begin
      addr_hits = (addr[5:1] >= `FIRST_WORD_INDEX) &&
                  (addr[5:1] <= `LAST_WORD_INDEX);
    end
  endfunction

  // Channel number of a byte address; both bytes give the same word
  function [3:0] addr_channel;
    input [5:0] addr;
    reg   [4:0] index;
    begin
      index        = addr[5:1] - `FIRST_WORD_INDEX;
      addr_channel = index[3:0];
    end
  endfunction

  // Rate and acceleration channels carry 14 data bits
  function channel_wide;
    input [3:0] ch;
    begin
      channel_wide = (ch >= `CHANNEL_FIRST_WIDE) &&
                     (ch <= `CHANNEL_LAST_WIDE);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage is never looked at
  // Reset values match idle pin levels, so reset makes no false edge

  reg cs_meta;
  reg cs_sync;
  reg cs_prev;
  reg sclk_meta;
  reg sclk_sync;
  reg sclk_prev;
  reg din_meta;
  reg din_sync;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_prev   <= 1'b1;
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
      din_meta  <= 1'b0;
      din_sync  <= 1'b0;
    end
    else
    begin
      cs_meta   <= cs_b;
      cs_sync   <= cs_meta;
      cs_prev   <= cs_sync;
      sclk_meta <= sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      din_meta  <= din;
      din_sync  <= din_meta;
    end
  end

  wire frame_start = cs_prev & ~cs_sync;
  wire frame_end   = ~cs_prev & cs_sync;
  wire sclk_rise   = ~sclk_prev & sclk_sync & ~cs_sync;
  wire sclk_fall   = sclk_prev & ~sclk_sync & ~cs_sync;

  //////////////////////////////////////////////////////////////////////
  // Sample intake

  wire        sample_ok = sample_valid && (sample_channel <= `CHANNEL_LAST);
  reg  [13:0] sample_field;

  // Narrow channels store zero in the two meaningless bits
  always @*
  begin
    if (channel_wide(sample_channel))
    begin
      sample_field = sample_data;
    end
    else
    begin
      sample_field = {2'b00, sample_data[`NARROW_MSB:0]};
    end
  end

  reg  [3:0]  pending_channel;
  wire [13:0] stored_field;

  output_word_store u_store
  (
    .mclk  (mclk),
    .we    (sample_ok),
    .waddr (sample_channel),
    .wdata (sample_field),
    .raddr (pending_channel),
    .rdata (stored_field)
  );

  //////////////////////////////////////////////////////////////////////
  // Fresh flags, one per channel

  localparam ST_IDLE  = 2'b01;
  localparam ST_SHIFT = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         pending_valid;
  wire        capture = (state == ST_IDLE) && frame_start;
  reg  [10:0] fresh;

  genvar ch;
  generate
    for (ch = 0; ch < `CHANNEL_COUNT; ch = ch + 1)
    begin : g_fresh
      wire load_hit = sample_ok && (sample_channel == ch);
      wire read_hit = capture && pending_valid &&
                      (pending_channel == ch);
      always @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          fresh[ch] <= 1'b0;
        end
        else if (load_hit)
        begin
          fresh[ch] <= 1'b1;
        end
        else if (read_hit)
        begin
          fresh[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  assign fresh_sample_flag = fresh;

  //////////////////////////////////////////////////////////////////////
  // Answer word

  // The store reads one edge late, so a sample landing on the pending
  // channel just before capture would leave the flag newer than the
  // data; this copy keeps the two in step
  reg         bypass_hit;
  reg  [13:0] bypass_field;
  wire [13:0] answer_field = bypass_hit ? bypass_field : stored_field;
  reg  [15:0] answer_word;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bypass_hit   <= 1'b0;
      bypass_field <= `DATA_RESET;
    end
    else
    begin
      bypass_hit   <= sample_ok && (sample_channel == pending_channel);
      bypass_field <= sample_field;
    end
  end

  // Unmapped or refused requests answer with an all-zero word
  always @*
  begin
    answer_word = `WORD_RESET;
    if (pending_valid)
    begin
      answer_word[`FRESH_BIT]  = fresh[pending_channel];
      answer_word[`ALARM_BIT]  = error_alarm;
      answer_word[`DATA_MSB:0] = answer_field;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frame sequencer

  reg [15:0] tx_shift;
  reg [15:0] rx_shift;
  reg [4:0]  bit_count;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (frame_start)
        begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (frame_end)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Shift registers and request decode

  wire [5:0] req_addr = rx_shift[`REQ_ADDR_MSB:`REQ_ADDR_LSB];
  wire       req_read = (bit_count == `FRAME_BITS) &&
                        !rx_shift[`REQ_WRITE_BIT] &&
                        !rx_shift[`REQ_ZERO_BIT];
  // Only a complete read frame to a mapped word is remembered
  wire       req_ok   = req_read && addr_hits(req_addr);

  // Bit 15 stands from capture on, so the first falling edge must not
  // shift it away before the host samples it on the first rising edge
  wire       shift_out = sclk_fall && (bit_count != 5'h00);

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state           <= ST_IDLE;
      tx_shift        <= `WORD_RESET;
      rx_shift        <= `WORD_RESET;
      bit_count       <= 5'h00;
    end
    else
    begin
      state <= next_state;
      case (state)
        ST_IDLE:
        begin
          if (frame_start)
          begin
            bit_count <= 5'h00;
            rx_shift  <= `WORD_RESET;
            // Whole word taken in one edge so a sample cannot tear it
            tx_shift  <= answer_word;
          end
        end
        ST_SHIFT:
        begin
          if (sclk_rise && (bit_count != `FRAME_BITS))
          begin
            rx_shift  <= {rx_shift[14:0], din_sync};
            bit_count <= bit_count + 5'h01;
          end
          if (shift_out)
          begin
            tx_shift <= {tx_shift[14:0], 1'b0};
          end
        end
        default:
        begin
          bit_count <= 5'h00;
          tx_shift  <= `WORD_RESET;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Request latch

  // Short, write or unmapped frames leave a zero answer
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pending_channel <= `CHANNEL_SUPPLY;
      pending_valid   <= 1'b0;
    end
    else if ((state == ST_SHIFT) && frame_end)
    begin
      pending_valid <= req_ok;
      if (req_ok)
      begin
        pending_channel <= addr_channel(req_addr);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Serial output

  // Driven only while the frame is open
  assign dout    = tx_shift[15];
  assign dout_oe = (state == ST_SHIFT) & ~cs_sync;

endmodule // inertial_output_data_registers

// ===== rtl/inertial_defs.vh
// Constants for the inertial output data register bank.
// Included by bare name; holds definitions only.
`ifndef INERTIAL_DEFS_VH
`define INERTIAL_DEFS_VH

// Register byte addresses (each register also answers at address + 1)
`define SUPPLY_VOLTAGE_OUT_ADDR  6'h02
`define RATE_X_OUT_ADDR          6'h04
`define RATE_Y_OUT_ADDR          6'h06
`define RATE_Z_OUT_ADDR          6'h08
`define ACCEL_X_OUT_ADDR         6'h0a
`define ACCEL_Y_OUT_ADDR         6'h0c
`define ACCEL_Z_OUT_ADDR         6'h0e
`define TEMPERATURE_X_OUT_ADDR   6'h10
`define TEMPERATURE_Y_OUT_ADDR   6'h12
`define TEMPERATURE_Z_OUT_ADDR   6'h14
`define AUX_CONVERTER_OUT_ADDR   6'h16

// Word index range (byte address divided by two)
`define FIRST_WORD_INDEX         5'h01
`define LAST_WORD_INDEX          5'h0b

// Channel numbering of the sample port and the word store
`define CHANNEL_COUNT            11
`define CHANNEL_SUPPLY           4'h0
`define CHANNEL_FIRST_WIDE       4'h1
`define CHANNEL_LAST_WIDE        4'h6
`define CHANNEL_LAST             4'ha

// Field layout of an output word and of a request word
`define FRESH_BIT                15
`define ALARM_BIT                14
`define DATA_MSB                 13
`define NARROW_MSB               11
`define REQ_WRITE_BIT            15
`define REQ_ZERO_BIT             14
`define REQ_ADDR_MSB             13
`define REQ_ADDR_LSB             8

// Frame and reset values
`define FRAME_BITS               5'h10
`define WORD_RESET               16'h0000
`define DATA_RESET               14'h0000
`define FRESH_RESET              11'h000

`endif

// ===== rtl/output_word_store.v
// Small word store holding the latest measurement of each channel.
// Single clock; read data is registered and lags raddr by one edge.
`timescale 1ns/100ps

module output_word_store
(
  input  wire        mclk,
  input  wire        we,
  input  wire [3:0]  waddr,
  input  wire [13:0] wdata,
  input  wire [3:0]  raddr,
  output reg  [13:0] rdata
);

  reg [13:0] words [0:10];

  always @(posedge mclk)
  begin
    if (we)
    begin
      words[waddr] <= wdata;
    end
    rdata <= words[raddr];
  end

endmodule // output_word_store

// ===== tb/bank_chk.sv
// Checker on the bank's serial and sample pins.
// Sees only the bank's ports; bound below, one clock domain.
`timescale 1ns/100ps
module bank_chk
(
  input wire        mclk,
  input wire        rst_b,
  input wire        cs_b,
  input wire        sclk,
  input wire        dout,
  input wire        dout_oe,
  input wire        sample_valid,
  input wire [3:0]  sample_channel,
  input wire [10:0] fresh_sample_flag
);
  wire [10:0] flg = fresh_sample_flag;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Eight edges both high: the last shift has long settled
  sequence s_quiet;
    sclk[*8] and dout_oe[*8];
  endsequence
  chk_flag_sets: assert property (
    sample_valid && sample_channel < 4'hb |=> flg[$past(sample_channel)])
    else $error("flag not set");
  chk_flag_cause: assert property (
    !(sample_valid && sample_channel < 4'hb) |=> !(|(flg & ~$past(flg))))
    else $error("stray flag");
  chk_clear_framed: assert property (
    |($past(flg) & ~flg) |-> !$past(cs_b, 2))
    else $error("clear outside frame");
  chk_one_clear: assert property (
    $onehot0($past(flg) & ~flg))
    else $error("several cleared");
  chk_oe_opens: assert property (
    $fell(cs_b) |-> ##[1:6] dout_oe)
    else $error("no drive");
  chk_oe_closes: assert property (
    cs_b[*5] |-> !dout_oe)
    else $error("drive idle");
  chk_oe_held: assert property (
    !cs_b && dout_oe |=> dout_oe)
    else $error("drive lost");
  chk_bit_steady: assert property (
    s_quiet |-> $stable(dout))
    else $error("bit moved");
endmodule // bank_chk
bind inertial_output_data_registers bank_chk i_bank_chk
(
  .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .dout(dout),
  .dout_oe(dout_oe), .sample_valid(sample_valid),
  .sample_channel(sample_channel), .fresh_sample_flag(fresh_sample_flag)
);

// ===== tb/spi_host.sv
// Host model of the serial link, reading one frame per call.
// Clock idles high; caller enters just after an mclk edge.
`timescale 1ns/100ps
module spi_host
(
  output logic cs_b = 1'b1,
  output logic sclk = 1'b1,
  output logic din  = 1'b0,
  input  wire  dout
);
  // Request: two zero bits, address, free byte
  task automatic frame(input logic [15:0] tx, input int h,
                       output logic [15:0] rx);
    cs_b = 1'b0;
    #(h);
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = tx[i];
      #(h);
      sclk = 1'b1;
      #(h);
      rx[i] = dout;
    end
    cs_b = 1'b1;
    din = ~din; // Released line never keeps the stale bit
    #(2 * h);
  endtask
endmodule // spi_host

// ===== tb/inertial_output_data_registers_tb.sv
// Bench for the output register bank: samples in, serial reads out.
// The host model drives the link; expectations live in the bench.
`timescale 1ns/100ps
module inertial_output_data_registers_tb;
  logic        mclk, rst_b, sample_valid, error_alarm;
  logic [3:0]  sample_channel;
  logic [13:0] sample_data;
  wire         cs_b, sclk, din, dout, dout_oe;
  wire  [10:0] fresh_sample_flag;
  logic [13:0] store [11];
  logic [10:0] fr = 11'h000;
  logic [31:0] seed = 32'h0000_0039;
  int          n_errors = 0, num_checks = 0, last = -1, cycles = 0, ch;
  inertial_output_data_registers i_inertial_output_data_registers
  (
    .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .sample_valid(sample_valid),
    .sample_channel(sample_channel), .sample_data(sample_data),
    .error_alarm(error_alarm), .fresh_sample_flag(fresh_sample_flag)
  );
  spi_host i_spi_host (.cs_b(cs_b), .sclk(sclk), .din(din), .dout(dout));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] word_of(int c);
    logic [13:0] d;
    d = store[c];
    if (c == 0 || c > 6)
      d[13:12] = 2'b00;
    return {fr[c], error_alarm, d};
  endfunction
  function automatic logic [15:0] req(int c, int odd);
    return {2'b00, 6'(2 * c + 2 + odd), 8'(rnd())};
  endfunction
  task automatic check(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic put(input int c, input logic [13:0] d);
    @(posedge mclk);
    #1;
    sample_valid = 1'b1;
    sample_channel = 4'(c);
    sample_data = d;
    if (c < 11)
    begin
      store[c] = d;
      fr[c] = 1'b1;
    end
    @(posedge mclk);
    #1;
    sample_valid = 1'b0;
  endtask
  // Answer carries the word asked for by the previous frame
  task automatic xfer(input logic [15:0] rq, input int nxt, h);
    logic [15:0] rx, ex;
    @(posedge mclk);
    #1;
    ex = 16'(rnd());
    error_alarm = ex[3];
    ex = (last < 0) ? 16'h0000 : word_of(last);
    if (last >= 0)
      fr[last] = 1'b0;
    i_spi_host.frame(rq, h, rx);
    check(rx, ex);
    check({5'h00, fresh_sample_flag}, {5'h00, fr});
    last = nxt;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {rst_b, sample_valid, error_alarm} = 3'b000;
    sample_channel = 4'h0;
    sample_data = 14'h0000;
    repeat (8) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    for (ch = 0; ch < 16; ch++)
      put(ch, 14'(rnd()));
    put(4, 14'h3fff);
    put(7, 14'h3fff);
    for (ch = 0; ch < 11; ch++)
      xfer(req(ch, ch % 2), ch, 100);
    xfer({2'b10, 6'h04, 8'h00}, -1, 100);
    xfer({2'b01, 6'h04, 8'h00}, -1, 100);
    xfer({2'b00, 6'h18, 8'h00}, -1, 100);
    xfer(req(0, 1), 0, 300);
    repeat (24)
    begin
      ch = rnd() % 11;
      if (rnd() % 2)
        put(ch, 14'(rnd()));
      xfer(req(ch, ch % 2), ch, (rnd() % 2) ? 300 : 100);
    end
    // Sample one edge before capture rides along; one at capture waits
    xfer(req(5, 0), 5, 100);
    store[5] = 14'h1555;
    fr[5] = 1'b1;
    fork
      xfer(req(5, 1), 5, 100);
      begin
        repeat (2) @(posedge mclk);
        #1;
        sample_valid = 1'b1;
        sample_channel = 4'h5;
        sample_data = 14'h1555;
        @(posedge mclk);
        #1;
        sample_valid = 1'b0;
      end
    join
    fork
      xfer(req(5, 0), 5, 100);
      begin
        repeat (2) @(posedge mclk);
        put(5, 14'h2aaa);
      end
    join
    xfer(req(0, 0), 0, 100);
    report_and_stop();
  end
endmodule // inertial_output_data_registers_tb
